//--- pkg/prox_pkg.sv
/*
  Shared constants and types of the proximity sensor control block:
  command codes, field positions, reset values, phase lengths and timing.
  Assumes a 200 MHz system clock.
*/
package prox_pkg;
  // command codes selecting the 16-bit registers
  localparam logic [7:0] CMD_CONF1 = 8'h03;
  localparam logic [7:0] CMD_CONF3 = 8'h04;
  localparam logic [7:0] CMD_CANC = 8'h05;
  localparam logic [7:0] CMD_THLOW = 8'h06;
  localparam logic [7:0] CMD_THHIGH = 8'h07;
  localparam logic [7:0] CMD_RESULT = 8'h08;
  localparam logic [7:0] CMD_INTFLAG = 8'h0B;
  // arbitrary bus address
  localparam logic [6:0] BUS_ADDR_DEF = 7'h2A;
  // configuration word 1 fields
  localparam int CONF1_SD_BIT = 0;
  localparam int CONF1_IT_LSB = 1;
  localparam int CONF1_PERS_LSB = 4;
  localparam int CONF1_INTEN_LSB = 8;
  localparam int CONF1_LOGIC_BIT = 10;
  // configuration word 3 fields (high byte holds emitter current)
  localparam int CONF3_TRIG_BIT = 2;
  localparam int CONF3_AF_BIT = 3;
  localparam int CONF3_LED_LSB = 8;
  // interrupt flag fields
  localparam int FLAG_AWAY_BIT = 8;
  localparam int FLAG_CLOSE_BIT = 9;
  // reset values
  localparam logic [15:0] CONF1_RST = 16'h0001;
  localparam logic [15:0] CONF3_RST = 16'h0000;
  localparam logic [15:0] CANC_RST = 16'h0000;
  localparam logic [15:0] THLOW_RST = 16'h0000;
  localparam logic [15:0] THHIGH_RST = 16'hFFFF;
  // timing
  localparam int CLK_MHZ = 200;
  localparam int PWRUP_NS = 2500000;
  localparam int PWRUP_CYC = PWRUP_NS * CLK_MHZ / 1000;
  localparam int T_BASE_NS = 125000;
  localparam int HALF_BASE_CYC = (T_BASE_NS / 2) * CLK_MHZ / 1000;
  // integration period per select value, in units of half a base period
  localparam logic [4:0] IT_HALVES [8] = '{5'h02, 5'h03, 5'h04, 5'h05,
                                           5'h06, 5'h07, 5'h08, 5'h10};
  // forced sequence phase lengths in half integration periods, then the saturation limit of the hit counters
  localparam logic [3:0] TRIG_HALVES = 4'h1;
  localparam logic [3:0] AMB_HALVES = 4'h6;
  localparam logic [3:0] CONV_HALVES = 4'h2;
  localparam logic [3:0] SHUT_HALVES = 4'h2;
  localparam logic [2:0] PERS_MAX = 3'h4;

  typedef struct packed {
    logic [7:0] cmd;
    logic [15:0] data;
  } prox_wr_t;
endpackage

//--- src/prox_forced_sensor.sv
/*
  Control logic of a proximity sensor: register file reached over the serial
  bus, power-up delay, forced single measurement sequence and threshold
  interrupt. Assumes the analog front end presents proxSample on clk.
*/
`timescale 1ns/100ps
module prox_forced_sensor
  import prox_pkg::*;
#(
  parameter int PWRUP_CYC_P = PWRUP_CYC,
  parameter int HALF_CYC_P = HALF_BASE_CYC,
  parameter logic [6:0] BUS_ADDR = BUS_ADDR_DEF
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic sclClk,
  input wire logic sdaI,
  output logic sdaO,
  output logic sdaOe,
  output logic intPinO,
  output logic intPinOe,
  input wire logic [15:0] proxSample,
  output logic emitterOn,
  output logic emitterTail,
  output logic [7:0] emitterCurrent,
  output logic deviceReady,
  output logic measBusy
);
  typedef enum logic [2:0] {S_IDLE, S_TRIG, S_AMB, S_CONV, S_SHUT} prox_st_t;
  prox_wr_t wrReq;
  logic wrTog, cmdTog, rdTog, linkRst_q, linkRst_d;
  logic [7:0] cmdCode;
  logic [4:0] sy1_q, sy2_q, sy3_q;
  logic [15:0] rdWord_q, rdWord_d;
  logic sclS, sdaS, wrEv, cmdEv, rdEv, startCond, stopCond;

  prox_i2c_link #(.BUS_ADDR(BUS_ADDR)) u_link (
    .sclClk(sclClk),
    .linkRst(linkRst_q),
    .sdaI(sdaI),
    .sdaOe(sdaOe),
    .wrReq(wrReq),
    .wrTog(wrTog),
    .cmdCode(cmdCode),
    .cmdTog(cmdTog),
    .rdTog(rdTog),
    .rdWord(rdWord_q)
  );

  // pins and event flags from the bus domain pass two flip-flops
  always_ff @(posedge clk) begin
    sy1_q <= {sclClk, sdaI, wrTog, cmdTog, rdTog};
    sy2_q <= sy1_q;
    sy3_q <= sy2_q;
  end
  assign sclS = sy2_q[4];
  assign sdaS = sy2_q[3];
  assign startCond = sclS & sy3_q[4] & sy3_q[3] & ~sdaS;
  assign stopCond = sclS & sy3_q[4] & ~sy3_q[3] & sdaS;
  assign wrEv = sy2_q[2] & ~sy3_q[2];
  assign cmdEv = sy2_q[1] & ~sy3_q[1];
  assign rdEv = sy2_q[0] & ~sy3_q[0];

  // bus slave is held in reset between frames
  always_comb begin
    linkRst_d = linkRst_q;
    if (stopCond) begin
      linkRst_d = 1'b1;
    end else if (startCond) begin
      linkRst_d = 1'b0;
    end
  end

  // power-up delay
  logic [19:0] pwrCnt_q, pwrCnt_d;
  logic ready_q, ready_d;
  always_comb begin
    pwrCnt_d = pwrCnt_q;
    ready_d = ready_q;
    if (pwrCnt_q == 20'(PWRUP_CYC_P - 1)) begin
      ready_d = 1'b1;
    end else begin
      pwrCnt_d = pwrCnt_q + 20'h1;
    end
  end

  // register file
  logic [15:0] conf1_q, conf1_d, conf3_q, conf3_d, canc_q, canc_d;
  logic [15:0] thLow_q, thLow_d, thHigh_q, thHigh_d, result_q, result_d;
  logic [15:0] flagWord;
  logic flagClose_q, flagClose_d, flagAway_q, flagAway_d, trigReq;
  prox_st_t st_q, st_d;

  always_comb begin
    flagWord = 16'h0000;
    flagWord[FLAG_CLOSE_BIT] = flagClose_q;
    flagWord[FLAG_AWAY_BIT] = flagAway_q;
  end
  assign trigReq = wrEv && ready_q && wrReq.cmd == CMD_CONF3 && st_q == S_IDLE
                   && wrReq.data[CONF3_TRIG_BIT] && wrReq.data[CONF3_AF_BIT]
                   && !conf1_q[CONF1_SD_BIT];

  always_comb begin
    conf1_d = conf1_q;
    conf3_d = conf3_q;
    canc_d = canc_q;
    thLow_d = thLow_q;
    thHigh_d = thHigh_q;
    rdWord_d = rdWord_q;
    if (wrEv && ready_q) begin
      case (wrReq.cmd)
        CMD_CONF1: conf1_d = wrReq.data;
        CMD_CONF3: conf3_d = wrReq.data;
        CMD_CANC: canc_d = wrReq.data;
        CMD_THLOW: thLow_d = wrReq.data;
        CMD_THHIGH: thHigh_d = wrReq.data;
        default: begin
        end
      endcase
    end
    conf3_d[CONF3_TRIG_BIT] = 1'b0;
    if (cmdEv) begin
      case (cmdCode)
        CMD_CONF1: rdWord_d = conf1_q;
        CMD_CONF3: rdWord_d = conf3_q;
        CMD_CANC: rdWord_d = canc_q;
        CMD_THLOW: rdWord_d = thLow_q;
        CMD_THHIGH: rdWord_d = thHigh_q;
        CMD_RESULT: rdWord_d = result_q;
        CMD_INTFLAG: rdWord_d = flagWord;
        default: rdWord_d = 16'h0000;
      endcase
    end
  end

  // forced measurement sequence
  logic [17:0] halfLen_q, halfLen_d, cyc_q, cyc_d;
  logic [3:0] halfLeft_q, halfLeft_d;
  logic [21:0] phaseCyc_q, phaseCyc_d;
  logic [15:0] sample_q, sample_d;
  logic resDone;
  always_comb begin
    st_d = st_q;
    halfLen_d = halfLen_q;
    cyc_d = cyc_q + 18'h1;
    halfLeft_d = halfLeft_q;
    phaseCyc_d = phaseCyc_q + 22'h1;
    sample_d = sample_q;
    resDone = 1'b0;
    if (st_q == S_IDLE) begin
      cyc_d = 18'h0;
      phaseCyc_d = 22'h0;
      if (trigReq) begin
        st_d = S_TRIG;
        halfLeft_d = TRIG_HALVES;
        // unit of the phase counter is half an integration period
        halfLen_d = 18'(HALF_CYC_P * int'(IT_HALVES[conf1_q[CONF1_IT_LSB +: 3]]) / 2);
      end
    end else if (cyc_q == halfLen_q - 18'h1) begin
      cyc_d = 18'h0;
      halfLeft_d = halfLeft_q - 4'h1;
      if (halfLeft_q == 4'h1) begin
        phaseCyc_d = 22'h0;
        case (st_q)
          S_TRIG: begin
            st_d = S_AMB;
            halfLeft_d = AMB_HALVES;
          end
          S_AMB: begin
            st_d = S_CONV;
            halfLeft_d = CONV_HALVES;
          end
          S_CONV: begin
            st_d = S_SHUT;
            halfLeft_d = SHUT_HALVES;
            sample_d = proxSample > canc_q ? proxSample - canc_q : 16'h0000;
          end
          default: begin
            st_d = S_IDLE;
            resDone = 1'b1;
          end
        endcase
      end
    end
  end

  // threshold interrupt
  logic [2:0] closeCnt_q, closeCnt_d, awayCnt_q, awayCnt_d, pers;
  logic logicLvl_q, logicLvl_d, closeFire, awayFire, clrFlags;
  assign pers = 3'({1'b0, conf1_q[CONF1_PERS_LSB +: 2]} + 3'h1);
  assign clrFlags = rdEv && cmdCode == CMD_INTFLAG;
  always_comb begin
    result_d = result_q;
    closeCnt_d = closeCnt_q;
    awayCnt_d = awayCnt_q;
    if (resDone) begin
      result_d = sample_q;
      closeCnt_d = 3'h0;
      awayCnt_d = 3'h0;
      if (sample_q > thHigh_q) begin
        closeCnt_d = closeCnt_q == PERS_MAX ? PERS_MAX : closeCnt_q + 3'h1;
      end
      if (sample_q < thLow_q) begin
        awayCnt_d = awayCnt_q == PERS_MAX ? PERS_MAX : awayCnt_q + 3'h1;
      end
    end
    closeFire = resDone && closeCnt_d == pers && closeCnt_q != pers;
    awayFire = resDone && awayCnt_d == pers && awayCnt_q != pers;
    flagClose_d = flagClose_q & ~clrFlags;
    flagAway_d = flagAway_q & ~clrFlags;
    logicLvl_d = logicLvl_q;
    if (conf1_q[CONF1_LOGIC_BIT]) begin
      if (closeFire) begin
        logicLvl_d = 1'b1;
      end else if (awayFire) begin
        logicLvl_d = 1'b0;
      end
    end else begin
      logicLvl_d = 1'b0;
      if (closeFire && conf1_q[CONF1_INTEN_LSB + 1]) begin
        flagClose_d = 1'b1;
      end
      if (awayFire && conf1_q[CONF1_INTEN_LSB]) begin
        flagAway_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      linkRst_q <= 1'b1;
      pwrCnt_q <= 20'h0;
      ready_q <= 1'b0;
      conf1_q <= CONF1_RST;
      conf3_q <= CONF3_RST;
      canc_q <= CANC_RST;
      thLow_q <= THLOW_RST;
      thHigh_q <= THHIGH_RST;
      result_q <= 16'h0000;
      rdWord_q <= 16'h0000;
      st_q <= S_IDLE;
      halfLen_q <= 18'h1;
      cyc_q <= 18'h0;
      halfLeft_q <= 4'h0;
      phaseCyc_q <= 22'h0;
      sample_q <= 16'h0000;
      closeCnt_q <= 3'h0;
      awayCnt_q <= 3'h0;
      flagClose_q <= 1'b0;
      flagAway_q <= 1'b0;
      logicLvl_q <= 1'b0;
      emitterOn <= 1'b0;
      emitterTail <= 1'b0;
      intPinOe <= 1'b0;
    end else begin
      linkRst_q <= linkRst_d;
      pwrCnt_q <= pwrCnt_d;
      ready_q <= ready_d;
      conf1_q <= conf1_d;
      conf3_q <= conf3_d;
      canc_q <= canc_d;
      thLow_q <= thLow_d;
      thHigh_q <= thHigh_d;
      result_q <= result_d;
      rdWord_q <= rdWord_d;
      st_q <= st_d;
      halfLen_q <= halfLen_d;
      cyc_q <= cyc_d;
      halfLeft_q <= halfLeft_d;
      phaseCyc_q <= phaseCyc_d;
      sample_q <= sample_d;
      closeCnt_q <= closeCnt_d;
      awayCnt_q <= awayCnt_d;
      flagClose_q <= flagClose_d;
      flagAway_q <= flagAway_d;
      logicLvl_q <= logicLvl_d;
      emitterOn <= st_d == S_CONV;
      emitterTail <= st_d == S_SHUT;
      intPinOe <= logicLvl_d | flagClose_d | flagAway_d;
    end
  end

  assign sdaO = 1'b0;
  assign intPinO = 1'b0;
  assign emitterCurrent = conf3_q[CONF3_LED_LSB +: 8];
  assign deviceReady = ready_q;
  assign measBusy = st_q != S_IDLE;

  sequence s_leave(prox_st_t s);
    st_q == s && st_d != s;
  endsequence
  property p_ready;
    @(posedge clk) disable iff (sys_rst)
    $rose(ready_q) |-> pwrCnt_q == 20'(PWRUP_CYC_P - 1) && !$past(ready_q);
  endproperty
  a_ready: assert property (p_ready) else $error("ready before power-up delay");
  property p_trig;
    @(posedge clk) disable iff (sys_rst)
    s_leave(S_TRIG) |-> phaseCyc_q == 22'(halfLen_q - 18'h1) ##1 st_q == S_AMB;
  endproperty
  a_trig: assert property (p_trig) else $error("trigger wait wrong");
  property p_amb;
    @(posedge clk) disable iff (sys_rst)
    s_leave(S_AMB) |-> phaseCyc_q == 22'(6 * halfLen_q - 1) ##1 emitterOn;
  endproperty
  a_amb: assert property (p_amb) else $error("ambient phase length wrong");
  property p_conv;
    @(posedge clk) disable iff (sys_rst)
    s_leave(S_CONV) |-> phaseCyc_q == 22'(2 * halfLen_q - 1) && emitterOn;
  endproperty
  a_conv: assert property (p_conv) else $error("conversion length wrong");
  property p_shut;
    @(posedge clk) disable iff (sys_rst)
    s_leave(S_SHUT) |-> phaseCyc_q == 22'(2 * halfLen_q - 1) ##1 result_q == $past(sample_q);
  endproperty
  a_shut: assert property (p_shut) else $error("shutdown phase wrong");
  property p_idle;
    @(posedge clk) disable iff (sys_rst)
    s_leave(S_SHUT) |=> st_q == S_IDLE ##1 !emitterOn && !emitterTail;
  endproperty
  a_idle: assert property (p_idle) else $error("not idle after sequence");
  property p_start;
    @(posedge clk) disable iff (sys_rst)
    (st_q == S_IDLE && st_d == S_TRIG) |-> !conf1_q[CONF1_SD_BIT] && ready_q
      ##1 halfLen_q == 18'(HALF_CYC_P * int'(IT_HALVES[conf1_q[CONF1_IT_LSB +: 3]]) / 2);
  endproperty
  a_start: assert property (p_start) else $error("start while inactive");
  property p_pers;
    @(posedge clk) disable iff (sys_rst)
    $rose(flagClose_q) |-> closeCnt_q == pers && $past(resDone);
  endproperty
  a_pers: assert property (p_pers) else $error("flag before hit count");
  property p_pin;
    @(posedge clk) disable iff (sys_rst)
    intPinOe |-> intPinO == 1'b0 && (flagClose_q || flagAway_q || logicLvl_q);
  endproperty
  a_pin: assert property (p_pin) else $error("interrupt pin without cause");
  property p_logic;
    @(posedge clk) disable iff (sys_rst)
    (conf1_q[CONF1_LOGIC_BIT] && awayFire && !closeFire) |=> !logicLvl_q ##1 !intPinOe;
  endproperty
  a_logic: assert property (p_logic) else $error("logic mode not released");
endmodule

//--- src/prox_i2c_link.sv
/*
  Serial bus slave of the proximity sensor, clocked by the bus clock.
  Assumes linkRst is held from a stop condition until a start condition and
  released before the first falling bus clock edge of the frame.
*/
`timescale 1ns/100ps
module prox_i2c_link
  import prox_pkg::*;
#(
  parameter logic [6:0] BUS_ADDR = BUS_ADDR_DEF
) (
  input wire logic sclClk,
  input wire logic linkRst,
  input wire logic sdaI,
  output logic sdaOe,
  output prox_wr_t wrReq,
  output logic wrTog,
  output logic [7:0] cmdCode,
  output logic cmdTog,
  output logic rdTog,
  input wire logic [15:0] rdWord
);
  typedef enum logic [2:0] {L_ADDR, L_CMD, L_DLO, L_DHI, L_RD, L_IGN} prox_lph_t;
  prox_lph_t ph_q, ph_d, phBase;
  logic [3:0] bitCnt_q, bitCnt_d, bitBase;
  logic [7:0] sh_q, sh_d, dlo_q, dlo_d, cmd_q, cmd_d, byteIn;
  logic [15:0] rdSh_q, rdSh_d;
  logic ack_q, ack_d, wrT_q, wrT_d, cmdT_q, cmdT_d, rdT_q, rdT_d, sdaHi_q, sdaHi_d;
  logic restart_q, restart_d, drv_q, drv_d;
  prox_wr_t wr_q, wr_d;

  // rising bus clock: sample and decode bytes
  always_comb begin
    phBase = restart_q ? L_ADDR : ph_q;
    bitBase = restart_q ? 4'h0 : bitCnt_q;
    byteIn = {sh_q[6:0], sdaI};
    ph_d = phBase;
    bitCnt_d = bitBase + 4'h1;
    sh_d = byteIn;
    dlo_d = dlo_q;
    cmd_d = cmd_q;
    rdSh_d = rdSh_q;
    ack_d = 1'b0;
    wrT_d = wrT_q;
    cmdT_d = cmdT_q;
    rdT_d = rdT_q;
    wr_d = wr_q;
    sdaHi_d = sdaI;
    if (bitBase == 4'h8) begin
      bitCnt_d = 4'h0;
      if (phBase == L_RD && sdaI) begin
        ph_d = L_IGN;
      end
    end else begin
      if (phBase == L_RD) begin
        rdSh_d = {rdSh_q[14:0], 1'b0};
      end
      if (bitBase == 4'h7) begin
        case (phBase)
          L_ADDR: begin
            if (byteIn[7:1] == BUS_ADDR) begin
              ack_d = 1'b1;
              if (byteIn[0]) begin
                ph_d = L_RD;
                rdSh_d = {rdWord[7:0], rdWord[15:8]};
                rdT_d = 1'b1;
              end else begin
                ph_d = L_CMD;
              end
            end else begin
              ph_d = L_IGN;
            end
          end
          L_CMD: begin
            cmd_d = byteIn;
            cmdT_d = 1'b1;
            ack_d = 1'b1;
            ph_d = L_DLO;
          end
          L_DLO: begin
            dlo_d = byteIn;
            ack_d = 1'b1;
            ph_d = L_DHI;
          end
          L_DHI: begin
            wr_d = '{cmd: cmd_q, data: {byteIn, dlo_q}};
            wrT_d = 1'b1;
            ack_d = 1'b1;
            ph_d = L_IGN;
          end
          default: begin
          end
        endcase
      end
    end
  end

  always_ff @(posedge sclClk or posedge linkRst) begin
    if (linkRst) begin
      ph_q <= L_ADDR;
      bitCnt_q <= 4'h0;
      sh_q <= 8'h00;
      dlo_q <= 8'h00;
      cmd_q <= 8'h00;
      rdSh_q <= 16'h0000;
      ack_q <= 1'b0;
      sdaHi_q <= 1'b0;
      // event flags stay up until the frame ends: one rising edge per event
      wrT_q <= 1'b0;
      cmdT_q <= 1'b0;
      rdT_q <= 1'b0;
      wr_q <= '0;
    end else begin
      ph_q <= ph_d;
      bitCnt_q <= bitCnt_d;
      sh_q <= sh_d;
      dlo_q <= dlo_d;
      cmd_q <= cmd_d;
      rdSh_q <= rdSh_d;
      ack_q <= ack_d;
      sdaHi_q <= sdaHi_d;
      wrT_q <= wrT_d;
      cmdT_q <= cmdT_d;
      rdT_q <= rdT_d;
      wr_q <= wr_d;
    end
  end

  // falling bus clock: repeated start detection and data line drive
  always_comb begin
    restart_d = sdaHi_q & ~sdaI;
    if (restart_d) begin
      drv_d = 1'b0;
    end else if (bitCnt_q == 4'h8) begin
      drv_d = ack_q;
    end else begin
      drv_d = (ph_q == L_RD) & ~rdSh_q[15];
    end
  end

  always_ff @(negedge sclClk or posedge linkRst) begin
    if (linkRst) begin
      restart_q <= 1'b0;
      drv_q <= 1'b0;
    end else begin
      restart_q <= restart_d;
      drv_q <= drv_d;
    end
  end

  assign sdaOe = drv_q;
  assign wrReq = wr_q;
  assign wrTog = wrT_q;
  assign cmdCode = cmd_q;
  assign cmdTog = cmdT_q;
  assign rdTog = rdT_q;
endmodule

//--- test/pfmi_host_model.sv
/*
  Host side of the serial bus and the interrupt line: a bus master with
  register write and read tasks, and the pull-ups on both lines.
  Assumes the device pulls the data line low only while sdaOe is high.
*/
`timescale 1ns/100ps
module pfmi_host_model
  import prox_pkg::*;
(
  output logic sclClk,
  output logic sdaI,
  input wire logic sdaOe,
  input wire logic sdaO,
  input wire logic intPinOe,
  output logic intN
);
  localparam realtime Q = 31.25;
  logic hostOe = 1'b0;

  initial sclClk = 1'b1;
  // wired-and data line with pull-up
  assign sdaI = (hostOe || (sdaOe && !sdaO)) ? 1'b0 : 1'b1;
  // interrupt line pull-up
  assign intN = intPinOe ? 1'b0 : 1'b1;

  task automatic bitx(input logic b, output logic r);
    hostOe = !b;
    #Q sclClk = 1'b1;
    #Q r = sdaI;
    #Q sclClk = 1'b0;
    #Q;
  endtask

  task automatic byteX(input logic [7:0] tx, input logic ackIn, output logic [7:0] rx,
                       output logic ackOut);
    for (int i = 7; i >= 0; i--) bitx(tx[i], rx[i]);
    bitx(ackIn, ackOut);
  endtask

  // start, or repeated start when the clock is low
  task automatic start();
    hostOe = 1'b0;
    #Q sclClk = 1'b1;
    #Q hostOe = 1'b1;
    #(2 * Q) sclClk = 1'b0;
    #Q;
  endtask

  task automatic stop();
    hostOe = 1'b1;
    #Q sclClk = 1'b1;
    #(2 * Q) hostOe = 1'b0;
    #(2 * Q);
  endtask

  // address, command, data low byte, data high byte
  task automatic writeReg(input logic [6:0] addr, input logic [7:0] cmd,
                          input logic [15:0] data, output logic ok);
    logic [7:0] d;
    logic [3:0] a;
    start();
    byteX({addr, 1'b0}, 1'b1, d, a[0]);
    byteX(cmd, 1'b1, d, a[1]);
    byteX(data[7:0], 1'b1, d, a[2]);
    byteX(data[15:8], 1'b1, d, a[3]);
    stop();
    ok = (a === 4'h0);
  endtask

  // command, repeated start, then low byte acked and high byte not acked
  task automatic readReg(input logic [7:0] cmd, output logic [15:0] data,
                         output logic ok);
    logic [7:0] d;
    logic [2:0] a;
    logic n;
    start();
    byteX({BUS_ADDR_DEF, 1'b0}, 1'b1, d, a[0]);
    byteX(cmd, 1'b1, d, a[1]);
    start();
    byteX({BUS_ADDR_DEF, 1'b1}, 1'b1, d, a[2]);
    byteX(8'hFF, 1'b0, data[7:0], n);
    byteX(8'hFF, 1'b1, data[15:8], n);
    stop();
    ok = (a === 3'h0);
  endtask
endmodule

//--- test/test_proximity_forced_measure_irq.sv
/*
  Self-checking bench of the proximity sensor control block.
  Assumes the host model drives the serial bus; counts are shortened.
*/
`timescale 1ns/100ps
module test_proximity_forced_measure_irq
  import prox_pkg::*;
;
  localparam int PWR = 2000;
  localparam int HALF = 10;
  localparam int P8 = 16 * HALF;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [15:0] proxSample = 16'h0000;
  logic sclClk, sdaI, sdaO, sdaOe, intPinO, intPinOe, intN, ok;
  logic emitterOn, emitterTail, deviceReady, measBusy;
  logic [7:0] emitterCurrent;
  logic [15:0] rd;
  int bad_count = 0;
  int n_tests = 0;
  int rdyCnt, busyCnt, onCnt, tailCnt, preCnt;

  always #2.5 clk = ~clk;

  prox_forced_sensor #(.PWRUP_CYC_P(PWR), .HALF_CYC_P(HALF)) dut (
    .clk(clk), .sys_rst(sys_rst), .sclClk(sclClk), .sdaI(sdaI), .sdaO(sdaO),
    .sdaOe(sdaOe), .intPinO(intPinO), .intPinOe(intPinOe), .proxSample(proxSample),
    .emitterOn(emitterOn), .emitterTail(emitterTail), .emitterCurrent(emitterCurrent),
    .deviceReady(deviceReady), .measBusy(measBusy));

  pfmi_host_model host (.sclClk(sclClk), .sdaI(sdaI), .sdaOe(sdaOe), .sdaO(sdaO),
    .intPinOe(intPinOe), .intN(intN));

  // phase length counters
  always @(posedge clk) begin
    if (!sys_rst && deviceReady !== 1'b1) rdyCnt <= rdyCnt + 1;
    if (measBusy === 1'b1) busyCnt <= busyCnt + 1;
    if (emitterOn === 1'b1) onCnt <= onCnt + 1;
    if (emitterTail === 1'b1) tailCnt <= tailCnt + 1;
    if (measBusy === 1'b1 && onCnt == 0 && emitterOn !== 1'b1 && emitterTail !== 1'b1)
      preCnt <= preCnt + 1;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] cmd, input logic [15:0] d);
    host.writeReg(BUS_ADDR_DEF, cmd, d, ok);
  endtask

  task automatic rdChk(input logic [7:0] cmd, input logic [15:0] exp);
    host.readReg(cmd, rd, ok);
    chk(rd, exp, $sformatf("read of %h", cmd));
    chk(ok, 1'b1, "read acknowledge");
  endtask

  function automatic logic [15:0] conf1(input int it, input int hits, input int en,
                                        input int lg);
    return 16'(it << 1 | (hits - 1) << 4 | en << 8 | lg << 10);
  endfunction

  task automatic waitBusy(input logic lvl, input int lim);
    int n;
    n = 0;
    while (measBusy !== lvl && n < lim) begin
      @(negedge clk);
      n++;
    end
    chk(measBusy, lvl, "busy wait");
  endtask

  task automatic measure(input logic [15:0] s);
    @(posedge clk) proxSample <= s;
    wr(CMD_CONF3, 16'hA50C);
    waitBusy(1'b1, 20);
    waitBusy(1'b0, 1000);
    repeat (2) @(negedge clk);
  endtask

  task automatic t_power();
    wr(CMD_THLOW, 16'h1234);
    chk(deviceReady, 1'b0, "ready too early");
    while (deviceReady !== 1'b1 && rdyCnt < 3 * PWR) @(negedge clk);
    chk(rdyCnt inside {[PWR - 1 : PWR + 1]}, 1'b1, "power-up count");
    rdChk(CMD_THLOW, THLOW_RST);
    rdChk(CMD_CONF1, CONF1_RST);
    rdChk(CMD_CONF3, CONF3_RST);
    rdChk(CMD_CANC, CANC_RST);
    rdChk(CMD_THHIGH, THHIGH_RST);
    rdChk(8'h20, 16'h0000);
    $display("test power done");
  endtask

  task automatic t_regs();
    wr(CMD_THHIGH, 16'hBEEF);
    rdChk(CMD_THHIGH, 16'hBEEF);
    host.writeReg(7'h2B, CMD_THHIGH, 16'h0101, ok);
    chk(ok, 1'b0, "foreign address acked");
    rdChk(CMD_THHIGH, 16'hBEEF);
    $display("test registers done");
  endtask

  task automatic t_forced();
    wr(CMD_CANC, 16'h0100);
    wr(CMD_CONF1, conf1(7, 1, 0, 0));
    @(negedge clk);
    {busyCnt, onCnt, tailCnt, preCnt} = '0;
    measure(16'h1234);
    chk(emitterCurrent, 8'hA5, "emitter current");
    chk(preCnt inside {[P8 * 7 / 2 - 1 : P8 * 7 / 2 + 1]}, 1'b1, "pre phases");
    chk(onCnt == P8, 1'b1, "conversion length");
    chk(tailCnt == P8, 1'b1, "shutdown length");
    chk(busyCnt inside {[P8 * 11 / 2 - 1 : P8 * 11 / 2 + 1]}, 1'b1, "sequence");
    chk({emitterOn, emitterTail}, 2'b00, "emitter left on");
    rdChk(CMD_RESULT, 16'h1134);
    rdChk(CMD_CONF3, 16'hA508);
    repeat (500) @(negedge clk);
    chk(busyCnt inside {[P8 * 11 / 2 - 1 : P8 * 11 / 2 + 1]}, 1'b1, "rerun");
    $display("test forced done");
  endtask

  task automatic t_hits();
    wr(CMD_CANC, 16'h0000);
    wr(CMD_THHIGH, 16'h0064);
    for (int n = 1; n <= 4; n++) begin
      wr(CMD_CONF1, conf1(0, n, 2, 0));
      measure(16'h0000);
      host.readReg(CMD_INTFLAG, rd, ok);
      for (int k = 1; k <= n; k++) begin
        measure(16'h00C8);
        chk(intPinOe, k == n, "hit count");
        chk(intN, k != n, "interrupt line");
      end
      rdChk(CMD_INTFLAG, 16'h0200);
      chk(intPinOe, 1'b0, "line after flag read");
    end
    for (int j = 0; j < 8; j++) begin
      measure(j % 4 == 0 ? 16'h0000 : 16'h00C8);
      chk(intPinOe, 1'b0, "isolated hits");
    end
    rdChk(CMD_INTFLAG, 16'h0000);
    wr(CMD_THLOW, 16'h0032);
    wr(CMD_CONF1, conf1(0, 1, 1, 0));
    measure(16'h000A);
    chk(intPinOe, 1'b1, "below lower");
    rdChk(CMD_INTFLAG, 16'h0100);
    chk({intPinO, sdaO}, 2'b00, "line driven high");
    $display("test hits done");
  endtask

  task automatic t_logic();
    wr(CMD_CONF1, conf1(0, 1, 3, 1));
    measure(16'h00C8);
    chk(intPinOe, 1'b1, "logic set");
    measure(16'h0046);
    chk(intPinOe, 1'b1, "logic hold");
    measure(16'h000A);
    chk(intPinOe, 1'b0, "logic release");
    $display("test logic done");
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    @(negedge clk);
    t_power();
    t_regs();
    t_forced();
    t_hits();
    t_logic();
    print_verdict();
  end

  initial begin
    #500000;
    bad_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    print_verdict();
  end
endmodule
